// ### design/fts_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Heater on below 150 C set point, off above it.
// - At overheat limit near 185 C, open relay, cut heater, halt printing.
// - Overheat relay-cut input reports overheat fault code and stops printing.
// - Relay-cut opens heater relay regardless of normal regulation.
// - Thermistor shutdown flag reports sensor cut-off fault and stops printing.
// - Warm-up threshold not reached in time gives warm-up timeout fault.
// - Heater drive held on too long gives stuck-heater fault.
// - Active-low heater drive output switches the heater lamps.
// - Roller temperature arrives as a digital converter value.
module fts_supervisor
  import fts_pkg::*;
#(
  parameter logic [TEMP_W-1:0] SETPOINT = FTS_SETPOINT_C,
  parameter logic [TEMP_W-1:0] OVERHEAT_LIMIT = FTS_OVERHEAT_C,
  parameter logic [TEMP_W-1:0] WARMUP_THR = FTS_WARMUP_THR_C,
  parameter logic [CNT_W-1:0] WARMUP_LIMIT = CNT_W'(WARMUP_CYC),
  parameter logic [CNT_W-1:0] HEATON_LIMIT = CNT_W'(HEATON_CYC)
)(
  input wire logic core_clk_i, // Clock, 100 MHz
  input wire logic rst_b_i, // Async reset, active low
  input wire logic [TEMP_W-1:0] adc_temp_i, // Converted roller temperature
  input wire logic adc_valid_i, // New conversion result
  input wire logic overheat_relay_cut_i, // Overheat comparator level
  input wire logic thermistor_shutdown_flag_i, // Thermistor shutdown level
  output logic heater_drive_n_o, // Heater lamps, low = on
  output logic heater_relay_o, // Relay closed when high
  output logic print_enable_o, // Printing allowed
  output logic fuser_ready_o, // Warm-up done
  output logic [3:0] fault_code_o // Panel fault code
);
  typedef struct packed {
    fts_state_type st;
    logic [TEMP_W-1:0] temp;
    logic heat_on;
    logic drive_n;
    logic relay;
    logic prn_en;
    logic ready;
    logic [3:0] code;
  } fts_sup_type;
  fts_sup_type s_r, s_nxt;
  logic warm_exp, heat_exp;

  fts_timer u_warm (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .run_i(s_r.st == FTS_WARMUP),
    .limit_i(WARMUP_LIMIT),
    .expired_o(warm_exp)
  );
  fts_timer u_heat (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .run_i(s_r.heat_on),
    .limit_i(HEATON_LIMIT),
    .expired_o(heat_exp)
  );

  always_comb begin
    s_nxt = s_r;
    if (adc_valid_i) begin
      s_nxt.temp = adc_temp_i;
    end
    unique case (s_r.st)
      FTS_WARMUP, FTS_REGULATE: begin
        // Fault priority: sensor, overheat, timeouts
        if (thermistor_shutdown_flag_i) begin
          s_nxt.code = FAULT_SENSOR_CUTOFF;
        end else if (overheat_relay_cut_i) begin
          s_nxt.code = FAULT_OVERHEAT;
        end else if (s_r.temp >= OVERHEAT_LIMIT) begin
          s_nxt.code = FAULT_OVERHEAT;
        end else if (warm_exp && s_r.st == FTS_WARMUP) begin
          s_nxt.code = FAULT_WARMUP_TIMEOUT;
        end else if (heat_exp) begin
          s_nxt.code = FAULT_HEATER_STUCK;
        end
        if (s_nxt.code != FAULT_NONE) begin
          s_nxt.st = FTS_FAULT;
          s_nxt.heat_on = 1'b0;
          s_nxt.relay = 1'b0;
          s_nxt.prn_en = 1'b0;
          s_nxt.ready = 1'b0;
        end else begin
          s_nxt.relay = 1'b1;
          s_nxt.heat_on = (s_r.temp < SETPOINT);
          if (s_r.st == FTS_WARMUP && s_r.temp >= WARMUP_THR) begin
            s_nxt.st = FTS_REGULATE;
            s_nxt.ready = 1'b1;
            s_nxt.prn_en = 1'b1;
          end
        end
      end
      FTS_FAULT: begin
        s_nxt.heat_on = 1'b0;
        s_nxt.relay = 1'b0;
        s_nxt.prn_en = 1'b0;
      end
      default: begin
        s_nxt.st = FTS_FAULT;
        s_nxt.heat_on = 1'b0;
        s_nxt.relay = 1'b0;
        s_nxt.prn_en = 1'b0;
      end
    endcase
    // Pin level registered so the output comes straight from a flop
    s_nxt.drive_n = ~s_nxt.heat_on;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r.st <= FTS_WARMUP;
      s_r.temp <= '0;
      s_r.heat_on <= 1'b0;
      s_r.drive_n <= 1'b1;
      s_r.relay <= 1'b0;
      s_r.prn_en <= 1'b0;
      s_r.ready <= 1'b0;
      s_r.code <= FAULT_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign heater_drive_n_o = s_r.drive_n;
  assign heater_relay_o = s_r.relay;
  assign print_enable_o = s_r.prn_en;
  assign fuser_ready_o = s_r.ready;
  assign fault_code_o = s_r.code;

  property p_relay_cut_fault;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (overheat_relay_cut_i && !thermistor_shutdown_flag_i && s_r.st != FTS_FAULT)
        |=> (fault_code_o == FAULT_OVERHEAT && !heater_relay_o && !print_enable_o);
  endproperty
  a_relay_cut_fault: assert property (p_relay_cut_fault) else $error("relay cut not handled");
  property p_relay_open;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      overheat_relay_cut_i |=> !heater_relay_o;
  endproperty
  a_relay_open: assert property (p_relay_open) else $error("relay stayed closed");
  property p_thermistor;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (thermistor_shutdown_flag_i && s_r.st != FTS_FAULT)
        |=> (fault_code_o == FAULT_SENSOR_CUTOFF && !print_enable_o);
  endproperty
  a_thermistor: assert property (p_thermistor) else $error("sensor cutoff missed");
  property p_overheat_temp;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (s_r.temp >= OVERHEAT_LIMIT) |=> (!heater_relay_o && heater_drive_n_o);
  endproperty
  a_overheat_temp: assert property (p_overheat_temp) else $error("overheat not cut");
  property p_regulate;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (s_r.st == FTS_REGULATE && s_nxt.st == FTS_REGULATE)
        |=> (heater_drive_n_o == ($past(s_r.temp) >= SETPOINT));
  endproperty
  a_regulate: assert property (p_regulate) else $error("set point regulation wrong");
  sequence s_in_fault;
    s_r.st == FTS_FAULT;
  endsequence
  sequence s_fault_held;
    s_r.st == FTS_FAULT && heater_drive_n_o && $stable(fault_code_o);
  endsequence
  property p_latched;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      s_in_fault |=> s_fault_held ##1 s_fault_held;
  endproperty
  a_latched: assert property (p_latched) else $error("fault not latched");
  property p_warm_timeout;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (warm_exp && s_r.st == FTS_WARMUP && !thermistor_shutdown_flag_i
        && !overheat_relay_cut_i && s_r.temp < OVERHEAT_LIMIT)
        |=> fault_code_o == FAULT_WARMUP_TIMEOUT;
  endproperty
  a_warm_timeout: assert property (p_warm_timeout) else $error("warm-up timeout missed");
  property p_stuck;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (heat_exp && s_r.st != FTS_FAULT && !thermistor_shutdown_flag_i && !overheat_relay_cut_i
        && s_r.temp < OVERHEAT_LIMIT && !(warm_exp && s_r.st == FTS_WARMUP))
        |=> (fault_code_o == FAULT_HEATER_STUCK && heater_drive_n_o);
  endproperty
  a_stuck: assert property (p_stuck) else $error("stuck heater missed");
  property p_drive_level;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !heater_drive_n_o |-> (heater_relay_o && s_r.st != FTS_FAULT);
  endproperty
  a_drive_level: assert property (p_drive_level) else $error("heater on while unsafe");
  // Warm-up exit and steady-state checks
  property p_warm_ready;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (s_r.st == FTS_WARMUP && s_r.temp >= WARMUP_THR && s_r.temp < OVERHEAT_LIMIT
        && !thermistor_shutdown_flag_i && !overheat_relay_cut_i && !warm_exp && !heat_exp)
        |=> (fuser_ready_o && print_enable_o && heater_relay_o);
  endproperty
  a_warm_ready: assert property (p_warm_ready) else $error("warm-up exit missed");
  property p_fault_safe;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      s_in_fault |-> (!heater_relay_o && !print_enable_o && !fuser_ready_o);
  endproperty
  a_fault_safe: assert property (p_fault_safe) else $error("fault state not safe");
  property p_code_state;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (fault_code_o != FAULT_NONE) |-> s_in_fault;
  endproperty
  a_code_state: assert property (p_code_state) else $error("code without fault state");
  property p_ready_hold;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (fuser_ready_o && !thermistor_shutdown_flag_i && !overheat_relay_cut_i
        && s_r.temp < OVERHEAT_LIMIT && !heat_exp) |=> fuser_ready_o;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");
  property p_print_relay;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      print_enable_o |-> (heater_relay_o && fault_code_o == FAULT_NONE);
  endproperty
  a_print_relay: assert property (p_print_relay) else $error("printing while faulted");
endmodule // fts_supervisor
`default_nettype wire

// ### design/fts_pkg.sv
package fts_pkg;
  localparam int TEMP_W = 10;
  localparam int CNT_W = 36;
  localparam logic [TEMP_W-1:0] FTS_SETPOINT_C = 10'h096;
  localparam logic [TEMP_W-1:0] FTS_OVERHEAT_C = 10'h0B9;
  localparam logic [TEMP_W-1:0] FTS_WARMUP_THR_C = 10'h08C;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WARMUP_MS = 60000;
  localparam int HEATON_MS = 120000;
  localparam longint WARMUP_CYC = longint'(WARMUP_MS) * 1000000 / CLK_PERIOD_NS;
  localparam longint HEATON_CYC = longint'(HEATON_MS) * 1000000 / CLK_PERIOD_NS;
  localparam logic [3:0] FAULT_NONE = 4'h0;
  localparam logic [3:0] FAULT_SENSOR_CUTOFF = 4'h1;
  localparam logic [3:0] FAULT_WARMUP_TIMEOUT = 4'h2;
  localparam logic [3:0] FAULT_HEATER_STUCK = 4'h3;
  localparam logic [3:0] FAULT_OVERHEAT = 4'h4;
  localparam logic [CNT_W-1:0] CNT_ONE = 36'h000000001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 36'h000000000;
  typedef enum logic [1:0] {
    FTS_WARMUP = 2'b00,
    FTS_REGULATE = 2'b01,
    FTS_FAULT = 2'b10
  } fts_state_type;
endpackage

// ### design/fts_timer.sv
`timescale 1ns/1ns
`default_nettype none
module fts_timer
  import fts_pkg::*;
(
  input wire logic core_clk_i, // Clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic run_i, // Count while high, clear when low
  input wire logic [CNT_W-1:0] limit_i, // Expiry count
  output logic expired_o // Count reached limit
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic expired;
  } fts_tmr_type;
  fts_tmr_type s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (!run_i) begin
      s_nxt.cnt = CNT_ZERO;
      s_nxt.expired = 1'b0;
    end else if (s_r.cnt >= limit_i - CNT_ONE) begin
      s_nxt.expired = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + CNT_ONE;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign expired_o = s_r.expired;
endmodule // fts_timer
`default_nettype wire

// ### bench/fts_fuser_model.sv
`timescale 1ns/1ns
`default_nettype none
module fts_fuser_model
  import fts_pkg::*;
(
  input wire logic core_clk_i, // Clock
  input wire logic rst_b_i, // Reset, active low
  input wire logic heater_drive_n_i, // Lamps, low = on
  input wire logic heater_relay_i, // Relay closed when high
  input wire logic hold_i, // Pin the roller temperature
  input wire logic [TEMP_W-1:0] hold_temp_i, // Pinned temperature
  output logic [TEMP_W-1:0] adc_temp_o, // Converter result
  output logic adc_valid_o // Result valid
);
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      adc_temp_o <= 10'h000;
      adc_valid_o <= 1'b0;
    end else begin
      adc_valid_o <= 1'b1;
      if (hold_i) begin
        adc_temp_o <= hold_temp_i;
      end else if (!heater_drive_n_i && heater_relay_i) begin
        adc_temp_o <= adc_temp_o + 10'h004;
      end else if (adc_temp_o != 10'h000) begin
        adc_temp_o <= adc_temp_o - 10'h001;
      end
    end
  end
endmodule // fts_fuser_model
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fts_pkg::*;
  logic clk, rst_b, cut, therm, hold, drive_n, relay, prn, rdy, vld;
  logic [TEMP_W-1:0] temp, htemp;
  logic [3:0] code;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  fts_supervisor #(.WARMUP_LIMIT(36'h000000032), .HEATON_LIMIT(36'h000000050)) DUT (
    .core_clk_i(clk), .rst_b_i(rst_b), .adc_temp_i(temp), .adc_valid_i(vld),
    .overheat_relay_cut_i(cut), .thermistor_shutdown_flag_i(therm),
    .heater_drive_n_o(drive_n), .heater_relay_o(relay), .print_enable_o(prn),
    .fuser_ready_o(rdy), .fault_code_o(code));
  fts_fuser_model partner (.core_clk_i(clk), .rst_b_i(rst_b), .heater_drive_n_i(drive_n),
    .heater_relay_i(relay), .hold_i(hold), .hold_temp_i(htemp),
    .adc_temp_o(temp), .adc_valid_o(vld));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_code(input logic [3:0] e);
    checks++;
    if (code !== e) begin
      num_errors++;
      $display("[FAIL] %0t code %0h exp %0h", $time, code, e);
    end
  endtask
  // Order: drive_n, relay, print enable, ready
  task automatic chk_out(input logic [3:0] e);
    checks++;
    if ({drive_n, relay, prn, rdy} !== e) begin
      num_errors++;
      $display("[FAIL] %0t outs %0h exp %0h", $time, {drive_n, relay, prn, rdy}, e);
    end
  endtask
  task automatic reset_dut(input logic h, input logic [TEMP_W-1:0] t);
    @(posedge clk);
    rst_b <= 1'b0;
    hold <= h;
    htemp <= t;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic pin(input logic [TEMP_W-1:0] t);
    @(posedge clk);
    hold <= 1'b1;
    htemp <= t;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic c, input logic t);
    repeat (5) @(posedge clk);
    cut <= c;
    therm <= t;
    @(posedge clk);
    cut <= 1'b0;
    therm <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wait_code(input logic [3:0] e, input int n);
    for (int i = 0; i < n && code !== e; i++) begin
      @(posedge clk);
      #1;
    end
    #1;
    chk_code(e);
  endtask
  task automatic t_regulate();
    reset_dut(1'b0, 10'h000);
    repeat (60) @(posedge clk);
    pin(10'h0A0);
    chk_out(4'hF);
    pin(10'h078);
    chk_out(4'h7);
    chk_code(FAULT_NONE);
  endtask
  task automatic t_overheat();
    reset_dut(1'b1, 10'h0A0);
    pin(10'h0B8);
    chk_code(FAULT_NONE);
    pin(10'h0B9);
    chk_code(FAULT_OVERHEAT);
    chk_out(4'h8);
    pin(10'h064);
    chk_out(4'h8);
  endtask
  task automatic t_inputs();
    reset_dut(1'b1, 10'h0A0);
    pulse(1'b1, 1'b0);
    chk_code(FAULT_OVERHEAT);
    chk_out(4'h8);
    pulse(1'b0, 1'b1);
    chk_code(FAULT_OVERHEAT);
    reset_dut(1'b1, 10'h0A0);
    pulse(1'b1, 1'b1);
    chk_code(FAULT_SENSOR_CUTOFF);
    chk_out(4'h8);
  endtask
  task automatic t_timers();
    reset_dut(1'b1, 10'h064);
    wait_code(FAULT_WARMUP_TIMEOUT, 70);
    chk_out(4'h8);
    reset_dut(1'b1, 10'h091);
    repeat (60) @(posedge clk);
    chk_code(FAULT_NONE);
    wait_code(FAULT_HEATER_STUCK, 40);
    chk_out(4'h8);
  endtask
  initial begin
    rst_b = 1'b0;
    cut = 1'b0;
    therm = 1'b0;
    hold = 1'b0;
    htemp = 10'h000;
    t_regulate();
    t_overheat();
    t_inputs();
    t_timers();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
